// ===== design/fsq_bus_cycle.v
// one asynchronous bus cycle (write or read) on the flash pins
`timescale 1ns/1ps
`include "fsq_defines.vh"
module fsq_bus_cycle #(
  parameter AW = 19
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_start,
  input wire i_write,
  input wire [AW-1:0] i_addr,
  input wire [7:0] i_wdata,
  input wire [7:0] i_dq_in,
  output reg o_done,
  output reg [7:0] o_rdata,
  output reg [AW-1:0] o_addr,
  output reg [7:0] o_dq_out,
  output reg o_dq_oe,
  output reg o_ce_n,
  output reg o_we_n,
  output reg o_oe_n
);
  // strobe low time rounds up, at least one cycle
  localparam WLO = (`FSQ_WE_LOW_NS * `FSQ_CLK_MHZ + 999) / 1000;
  localparam WHI = (`FSQ_WE_HIGH_NS * `FSQ_CLK_MHZ + 999) / 1000;
  localparam RAC = (`FSQ_RD_ACC_NS * `FSQ_CLK_MHZ + 999) / 1000 + 1;
  localparam S_IDLE = 3'b001;
  localparam S_LOW = 3'b010;
  localparam S_HIGH = 3'b100;
  reg [2:0] state;
  reg [3:0] cnt;
  reg wr;

  // ----------------------------------------
  // strobe sequencer
  // ----------------------------------------
  // address, data and strobe move together (zero setup is allowed) and address and data
  // hold until after the strobe rises: address taken on the fall, data on the rise
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= S_IDLE;
      cnt <= 4'h0;
      wr <= 1'b0;
      o_done <= 1'b0;
      o_rdata <= 8'h00;
      o_addr <= {AW{1'b0}};
      o_dq_out <= 8'h00;
      o_dq_oe <= 1'b0;
      o_ce_n <= 1'b1;
      o_we_n <= 1'b1;
      o_oe_n <= 1'b1;
    end else if (i_ce) begin
      o_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_start) begin
            wr <= i_write;
            o_addr <= i_addr;
            o_dq_out <= i_wdata;
            o_dq_oe <= i_write;
            o_ce_n <= 1'b0;
            o_we_n <= ~i_write;
            o_oe_n <= i_write;
            cnt <= i_write ? WLO[3:0] : RAC[3:0];
            state <= S_LOW;
          end
        end
        S_LOW: begin
          if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
          end else begin
            if (!wr) begin
              o_rdata <= i_dq_in;
            end
            o_we_n <= 1'b1; // rising edge latches data
            o_oe_n <= 1'b1;
            cnt <= WHI[3:0];
            state <= S_HIGH;
          end
        end
        S_HIGH: begin
          o_ce_n <= 1'b1;
          o_dq_oe <= 1'b0;
          if (cnt > 4'h1) begin
            cnt <= cnt - 4'h1;
          end else begin
            o_done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fsq_bus_cycle

// ===== design/fsq_defines.vh
// constants for the flash command sequencer host controller
`ifndef FSQ_DEFINES_VH
`define FSQ_DEFINES_VH
`define FSQ_UNLOCK1_ADDR 19'h0_5555
`define FSQ_UNLOCK1_DATA 8'hAA
`define FSQ_UNLOCK2_ADDR 19'h0_2AAA
`define FSQ_UNLOCK2_DATA 8'h55
`define FSQ_SETUP_ADDR 19'h0_5555
`define FSQ_CMD_ERASE_SETUP 8'h80
`define FSQ_CMD_CHIP_CONFIRM 8'h10
`define FSQ_CMD_SECTOR_WIPE 8'h30
`define FSQ_CMD_BYTE_WRITE 8'hA0
`define FSQ_CMD_SUSPEND 8'hB0
`define FSQ_CMD_CONTINUE 8'h30
`define FSQ_CMD_RESET 8'hF0
`define FSQ_OP_CHIP_ERASE 3'h0
`define FSQ_OP_SECTOR_WIPE 3'h1
`define FSQ_OP_SECTOR_ADD 3'h2
`define FSQ_OP_BYTE_WRITE 3'h3
`define FSQ_OP_SUSPEND 3'h4
`define FSQ_OP_CONTINUE 3'h5
`define FSQ_OP_RESET 3'h6
`define FSQ_OP_READ 3'h7
`define FSQ_BIT_POLL 7
`define FSQ_BIT_TOGGLE 6
`define FSQ_BIT_FAIL 5
`define FSQ_BIT_TIMER 3
`define FSQ_CLK_MHZ 25
`define FSQ_WE_LOW_NS 80
`define FSQ_WE_HIGH_NS 35
`define FSQ_RD_ACC_NS 200
`define FSQ_RESET_WAIT_US 5
`define FSQ_SUSPEND_MAX_US 15
`endif

// ===== design/fsq_host.v
// host controller issuing program/erase command sequences to a parallel flash
`timescale 1ns/1ps
`include "fsq_defines.vh"
module fsq_host #(
  parameter AW = 19,
  parameter RESET_WAIT = `FSQ_RESET_WAIT_US * `FSQ_CLK_MHZ,
  parameter SUSP_WAIT = `FSQ_SUSPEND_MAX_US * `FSQ_CLK_MHZ,
  parameter POLL_LIMIT = 32'd750_000_000
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_ce,
  input wire i_req,
  input wire [2:0] i_op,
  input wire [AW-1:0] i_addr,
  input wire [7:0] i_data,
  input wire [7:0] i_dq_in,
  output reg o_busy,
  output reg o_done,
  output reg o_fail,
  output reg o_timeout,
  output reg [7:0] o_rdata,
  output reg o_erase_timer,
  output wire [AW-1:0] o_flash_addr,
  output wire [7:0] o_dq_out,
  output wire o_dq_oe,
  output wire o_ce_n,
  output wire o_we_n,
  output wire o_oe_n
);
  localparam S_IDLE = 6'b000001;
  localparam S_WRITE = 6'b000010;
  localparam S_POLL = 6'b000100;
  localparam S_WAIT = 6'b001000;
  localparam S_RDONE = 6'b010000;
  localparam S_FIN = 6'b100000;
  reg [5:0] state;
  reg [2:0] op;
  reg [AW-1:0] addr;
  reg [7:0] data;
  reg [2:0] step;
  reg [2:0] nsteps;
  reg [31:0] cnt;
  reg have_prev;
  reg prev_toggle;
  reg cyc_start;
  reg cyc_write;
  reg [AW-1:0] cyc_addr;
  reg [7:0] cyc_data;
  reg [AW-1:0] next_addr;
  reg [7:0] next_data;
  wire cyc_done;
  wire [7:0] cyc_rdata;

  // ----------------------------------------
  // pin cycle engine
  // ----------------------------------------
  // pins come straight from flip-flops inside the cycle engine
  fsq_bus_cycle #(.AW(AW)) u_cycle (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_start(cyc_start),
    .i_write(cyc_write),
    .i_addr(cyc_addr),
    .i_wdata(cyc_data),
    .i_dq_in(i_dq_in),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_addr(o_flash_addr),
    .o_dq_out(o_dq_out),
    .o_dq_oe(o_dq_oe),
    .o_ce_n(o_ce_n),
    .o_we_n(o_we_n),
    .o_oe_n(o_oe_n)
  );

  // ----------------------------------------
  // write sequence table
  // ----------------------------------------
  // address/data of the current write step for the chosen operation
  always @* begin
    next_addr = addr;
    next_data = data;
    case (step)
      3'd0: begin
        next_addr = `FSQ_UNLOCK1_ADDR;
        next_data = `FSQ_UNLOCK1_DATA;
      end
      3'd1: begin
        next_addr = `FSQ_UNLOCK2_ADDR;
        next_data = `FSQ_UNLOCK2_DATA;
      end
      3'd2: begin
        next_addr = `FSQ_SETUP_ADDR;
        next_data = (op == `FSQ_OP_BYTE_WRITE) ? `FSQ_CMD_BYTE_WRITE :
                    (op == `FSQ_OP_RESET) ? `FSQ_CMD_RESET : `FSQ_CMD_ERASE_SETUP;
      end
      3'd3: begin
        next_addr = (op == `FSQ_OP_BYTE_WRITE) ? addr : `FSQ_UNLOCK1_ADDR;
        next_data = (op == `FSQ_OP_BYTE_WRITE) ? data : `FSQ_UNLOCK1_DATA;
      end
      3'd4: begin
        next_addr = `FSQ_UNLOCK2_ADDR;
        next_data = `FSQ_UNLOCK2_DATA;
      end
      3'd5: begin
        // chip erase confirm at fixed address, block confirm at block address
        next_addr = (op == `FSQ_OP_CHIP_ERASE) ? `FSQ_SETUP_ADDR : addr;
        next_data = (op == `FSQ_OP_CHIP_ERASE) ? `FSQ_CMD_CHIP_CONFIRM :
                    `FSQ_CMD_SECTOR_WIPE;
      end
      default: begin
        // single-write commands carry no unlock cycles
        next_addr = addr;
        next_data = (op == `FSQ_OP_SUSPEND) ? `FSQ_CMD_SUSPEND :
                    (op == `FSQ_OP_CONTINUE) ? `FSQ_CMD_CONTINUE :
                    `FSQ_CMD_SECTOR_WIPE;
      end
    endcase
  end

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  // requests are refused while busy; device ignores overlapping ones anyway
  always @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      state <= S_IDLE;
      op <= 3'h0;
      addr <= {AW{1'b0}};
      data <= 8'h00;
      step <= 3'd0;
      nsteps <= 3'd0;
      cnt <= 32'h0000_0000;
      have_prev <= 1'b0;
      prev_toggle <= 1'b0;
      cyc_start <= 1'b0;
      cyc_write <= 1'b0;
      cyc_addr <= {AW{1'b0}};
      cyc_data <= 8'h00;
      o_busy <= 1'b0;
      o_done <= 1'b0;
      o_fail <= 1'b0;
      o_timeout <= 1'b0;
      o_rdata <= 8'h00;
      o_erase_timer <= 1'b0;
    end else if (i_ce) begin
      cyc_start <= 1'b0;
      o_done <= 1'b0;
      case (state)
        S_IDLE: begin
          if (i_req) begin
            op <= i_op;
            addr <= i_addr;
            data <= i_data;
            o_busy <= 1'b1;
            o_fail <= 1'b0;
            o_timeout <= 1'b0;
            cnt <= 32'h0000_0000;
            have_prev <= 1'b0;
            case (i_op)
              `FSQ_OP_CHIP_ERASE, `FSQ_OP_SECTOR_WIPE: begin
                step <= 3'd0;
                nsteps <= 3'd6;
              end
              `FSQ_OP_BYTE_WRITE: begin
                step <= 3'd0;
                nsteps <= 3'd4;
              end
              `FSQ_OP_RESET: begin
                step <= 3'd0; // unlock cycles then F0h
                nsteps <= 3'd3;
              end
              `FSQ_OP_READ: begin
                step <= 3'd0;
                nsteps <= 3'd0;
              end
              default: begin
                step <= 3'd6;
                nsteps <= 3'd7;
              end
            endcase
            if (i_op == `FSQ_OP_READ) begin
              cyc_write <= 1'b0;
              cyc_addr <= i_addr;
              cyc_start <= 1'b1;
              state <= S_RDONE;
            end else begin
              state <= S_WRITE;
            end
          end
        end
        S_WRITE: begin
          if (!cyc_start && !o_we_n) begin
            state <= S_WRITE;
          end
          if (cyc_done || (step == 3'd0 && !have_prev) || (step == 3'd6 && !have_prev)) begin
            if (have_prev && step == nsteps) begin
              have_prev <= 1'b0;
              case (op)
                `FSQ_OP_CHIP_ERASE, `FSQ_OP_BYTE_WRITE: state <= S_POLL;
                `FSQ_OP_SECTOR_WIPE, `FSQ_OP_SECTOR_ADD: begin
                  // blocks erase after the device's own timeout; host polls timer bit
                  o_erase_timer <= 1'b1;
                  state <= S_POLL;
                end
                `FSQ_OP_RESET: begin
                  cnt <= RESET_WAIT;
                  state <= S_WAIT;
                end
                `FSQ_OP_SUSPEND: begin
                  cnt <= SUSP_WAIT;
                  state <= S_WAIT;
                end
                default: state <= S_POLL;
              endcase
            end else begin
              cyc_write <= 1'b1;
              cyc_addr <= next_addr;
              cyc_data <= next_data;
              cyc_start <= 1'b1;
              have_prev <= 1'b1;
              step <= step + 3'd1;
            end
          end
        end
        S_POLL: begin
          // read status at target address until toggle stops
          if (!have_prev) begin
            cyc_write <= 1'b0;
            cyc_addr <= addr;
            cyc_start <= 1'b1;
            have_prev <= 1'b1;
          end else if (cyc_done) begin
            cnt <= cnt + 32'h0000_0001;
            prev_toggle <= cyc_rdata[`FSQ_BIT_TOGGLE];
            have_prev <= 1'b0;
            o_rdata <= cyc_rdata;
            o_erase_timer <= cyc_rdata[`FSQ_BIT_TIMER];
            if (cnt != 32'h0000_0000 && cyc_rdata[`FSQ_BIT_TOGGLE] == prev_toggle) begin
              state <= S_FIN;
            end else if (cyc_rdata[`FSQ_BIT_FAIL]) begin
              // re-read to see whether toggle stopped; if not, failure
              have_prev <= 1'b1;
              cyc_start <= 1'b1;
              state <= S_RDONE;
              o_fail <= 1'b1;
            end else if (cnt >= POLL_LIMIT) begin
              o_timeout <= 1'b1;
              state <= S_FIN;
            end
          end
        end
        S_RDONE: begin
          if (cyc_done) begin
            o_rdata <= cyc_rdata;
            if (o_fail && cyc_rdata[`FSQ_BIT_TOGGLE] == prev_toggle) begin
              o_fail <= 1'b0; // toggle stopped: success after all
            end
            state <= S_FIN;
          end
        end
        S_WAIT: begin
          if (cnt > 32'h0000_0001) begin
            cnt <= cnt - 32'h0000_0001;
          end else begin
            state <= S_FIN;
          end
        end
        S_FIN: begin
          // on failure the caller issues the reset operation to clear the device
          o_busy <= 1'b0;
          o_done <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // fsq_host

// ===== tb/fsq_flash_model.sv
// behavioural flash device answering the host controller's bus cycles
`timescale 1ns/1ps
module fsq_flash_model (
  input wire logic [18:0] i_addr,
  input wire logic [7:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_we_n,
  input wire logic i_oe_n,
  input wire logic i_fail_mode,
  output logic [7:0] o_dq
);
  logic [7:0] mem[int];
  logic [7:0] last = 8'h00;
  int la = 0;
  int st = 0;
  int kind = 0; // 0 program, 1 chip erase, 2 block erase
  int left = 0; // status reads still to give
  bit sus = 0;
  bit tog = 0;
  function automatic logic [7:0] rd(int a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction
  function automatic bit ul(int a, logic [7:0] d, int ua, logic [7:0] ud);
    return a == ua && d == ud;
  endfunction
  // a fixed count of status reads stands in for the long erase and program time
  task automatic go(int k, int n);
    kind = k;
    left = n;
    st = 0;
  endtask
  // -------------------------------------------------------------------
  // command decoder
  // -------------------------------------------------------------------
  task automatic wr(int a, logic [7:0] d);
    if (left > 0 || sus) begin
      if (d == 8'hF0 && (kind > 0 || sus)) begin left = 0; sus = 0; end
      else if (kind == 2 && left > 4 && d == 8'h30) left = 6;
      else if (kind == 2 && left > 0 && d == 8'hB0) begin left = 0; sus = 1; end
      else if (sus && d == 8'h30) begin left = 4; sus = 0; end
      else if (kind == 2 && left > 4) left = 0;
      return;
    end
    case (st)
      0, 3: st = ul(a, d, 'h5555, 8'hAA) ? st + 1 : 0;
      1, 4: st = ul(a, d, 'h2AAA, 8'h55) ? st + 1 : 0;
      2: st = d == 8'hA0 ? 6 : ul(a, d, 'h5555, 8'h80) ? 3 : 0;
      5: if (ul(a, d, 'h5555, 8'h10)) begin mem.delete(); go(1, 6); end
        else if (d == 8'h30) begin
          foreach (mem[k]) if (k[18:16] == a[18:16]) mem[k] = 8'hFF;
          go(2, 6);
        end else st = 0;
      default: begin mem[a] = rd(a) & d; go(0, 3); end
    endcase
  endtask
  // address on the falling strobe, data on the rising one
  // pins move in the same step as the strobe, so look 1 ns later while they are held
  always @(negedge i_we_n) begin
    #1;
    if (!i_ce_n) la = i_addr;
  end
  always @(posedge i_we_n) if (!i_ce_n) wr(la, i_dq);
  // each status read toggles; a failed erase keeps toggling until reset
  // select falls in the same step as the read strobe, so look 1 ns later
  always @(negedge i_oe_n) begin
    #1;
    if (!i_ce_n && left > 0) begin
      tog = ~tog;
      if (!i_fail_mode || kind == 0) left--;
    end
  end
  // released bus shows the inverse of the last byte, no pull resistors
  assign o_dq = (i_ce_n || i_oe_n) ? ~last : left > 0 ? {1'b0, tog, i_fail_mode && kind > 0,
    1'b0, kind != 2 || left <= 4, 3'b000} : rd(i_addr);
  always @(o_dq) if (!i_ce_n && !i_oe_n) last = o_dq;
endmodule // fsq_flash_model

// ===== tb/fsq_host_props.sv
// concurrent checks on the host controller's flash pins and request handshake
`timescale 1ns/1ps
module fsq_host_props #(
  parameter AW = 19
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_req,
  input wire [2:0] i_op,
  input wire o_busy,
  input wire o_fail,
  input wire [AW-1:0] o_flash_addr,
  input wire [7:0] o_dq_out,
  input wire o_dq_oe,
  input wire o_ce_n,
  input wire o_we_n,
  input wire o_oe_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // -------------------------------------------------------------------
  // write cycle shape
  // -------------------------------------------------------------------
  a_we_inside_ce: assert property (!o_we_n |-> !o_ce_n)
    else $error("write strobe without chip select");
  a_no_rw_clash: assert property (!o_we_n |-> o_oe_n)
    else $error("write and read strobes together");
  a_we_low_width: assert property ($fell(o_we_n) |-> ##1 !o_we_n ##1 o_we_n)
    else $error("write strobe width wrong");
  // data and address must hold up to the rising strobe, where data is latched
  a_data_at_rise: assert property ($rose(o_we_n) |-> o_dq_oe && !o_ce_n &&
    $stable(o_dq_out) && $stable(o_flash_addr)) else $error("write data not held");
  a_ce_after_we: assert property ($rose(o_we_n) |=> o_ce_n && !o_dq_oe)
    else $error("select not dropped after write");
  // -------------------------------------------------------------------
  // reads and handshake
  // -------------------------------------------------------------------
  a_read_no_drive: assert property (!o_oe_n |-> !o_dq_oe && !o_ce_n)
    else $error("status read while driving data");
  a_req_taken: assert property (i_req && !o_busy |=> o_busy)
    else $error("request not taken");
  a_idle_quiet: assert property (!o_busy |-> o_we_n && o_oe_n && !o_dq_oe)
    else $error("bus activity while idle");
  cover property (i_req && !o_busy && i_op == 3'h0);
  cover property (i_req && !o_busy && i_op == 3'h1);
  cover property ($rose(o_fail));
endmodule // fsq_host_props

bind fsq_host fsq_host_props #(.AW(AW)) u_props (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_op(i_op), .o_busy(o_busy),
  .o_fail(o_fail), .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe),
  .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n));

// ===== tb/tb_fsq_host.sv
// self-checking bench for the flash command sequencer host controller
`timescale 1ns/1ps
module tb_fsq_host;
  logic i_clk = 0;
  logic i_sys_rst = 1;
  logic i_req = 0;
  logic [2:0] i_op = 0;
  logic [18:0] i_addr = 0;
  logic [7:0] i_data = 0;
  logic fail_mode = 0;
  wire [7:0] flash_dq, dq_in, o_dq_out, o_rdata;
  wire [18:0] o_flash_addr;
  wire o_busy, o_done, o_fail, o_timeout, o_erase_timer, o_dq_oe, o_ce_n, o_we_n, o_oe_n;
  int n_errors = 0;
  int check_count = 0;
  integer seed = 6;
  logic [7:0] em[int];
  always #20 i_clk = ~i_clk;
  // pin level seen by the host: its own drive wins while enabled
  assign dq_in = o_dq_oe ? o_dq_out : flash_dq;
  fsq_host #(.RESET_WAIT(4), .SUSP_WAIT(4), .POLL_LIMIT(1000)) DUT (.i_clk(i_clk),
    .i_sys_rst(i_sys_rst), .i_ce(1'b1), .i_req(i_req), .i_op(i_op), .i_addr(i_addr),
    .i_data(i_data), .i_dq_in(dq_in), .o_busy(o_busy), .o_done(o_done), .o_fail(o_fail),
    .o_timeout(o_timeout), .o_rdata(o_rdata), .o_erase_timer(o_erase_timer),
    .o_flash_addr(o_flash_addr), .o_dq_out(o_dq_out), .o_dq_oe(o_dq_oe), .o_ce_n(o_ce_n),
    .o_we_n(o_we_n), .o_oe_n(o_oe_n));
  fsq_flash_model u_flash (.i_addr(o_flash_addr), .i_dq(o_dq_out), .i_ce_n(o_ce_n),
    .i_we_n(o_we_n), .i_oe_n(o_oe_n), .i_fail_mode(fail_mode), .o_dq(flash_dq));
  // -------------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------------
  function automatic logic [7:0] ex(int a);
    return em.exists(a) ? em[a] : 8'hFF;
  endfunction
  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // one request, held for the taking edge, then a bounded wait for done
  task automatic op(logic [2:0] o, logic [18:0] a, logic [7:0] d = 8'h00);
    int n;
    i_req = 1;
    i_op = o;
    i_addr = a;
    i_data = d;
    @(posedge i_clk) #1 i_req = 0;
    for (n = 0; n < 20000 && o_done !== 1'b1; n++) @(posedge i_clk) #1;
    if (o_done !== 1'b1) begin
      chk("done", 8'h00, 8'h01);
      tally_and_finish;
    end
  endtask
  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  initial begin
    logic [18:0] a;
    logic [7:0] d;
    repeat (4) @(posedge i_clk);
    #1 i_sys_rst = 0;
    op(7, 19'h0_0010);
    chk("blank read", o_rdata, 8'hFF);
    // few addresses, so some bytes get programmed twice
    repeat (10) begin
      a = {16'h0020, 3'($random(seed))};
      d = $random(seed);
      op(3, a, d);
      em[a] = ex(a) & d;
      op(7, a);
      chk("program", o_rdata, ex(a));
    end
    op(1, 19'h7_0123);
    chk("timer bit", o_erase_timer, 8'h01);
    chk("erase fail", o_fail, 8'h00);
    // add, suspend and resume with nothing running change nothing
    op(2, 19'h7_0000);
    op(4, 19'h0_0000);
    op(5, 19'h0_0000);
    op(7, a);
    chk("idle codes", o_rdata, ex(a));
    op(1, 19'h0_4000);
    foreach (em[k]) if (k[18:16] == 3'h0) em[k] = 8'hFF;
    op(7, a);
    chk("block erase", o_rdata, ex(a));
    op(3, a, 8'h5A);
    op(0, 19'h0_0000);
    em.delete();
    op(7, a);
    chk("chip erase", o_rdata, 8'hFF);
    chk("no timeout", o_timeout, 8'h00);
    fail_mode = 1;
    op(0, 19'h0_0000);
    chk("fail flag", o_fail, 8'h01);
    fail_mode = 0;
    op(6, 19'h0_0000);
    op(7, a);
    chk("after reset", o_rdata, 8'hFF);
    chk("fail cleared", o_fail, 8'h00);
    tally_and_finish;
  end
endmodule // tb_fsq_host
